// ===== rtl/sss_dev.sv
`timescale 1ns/1ns
// How it works
// - Supply good starts a 25 ms reset.
// - Power-up reset count holds at zero while the external reset pin is low.
// - Straps latched 25 ms after reset pulse.
// - All pins high-impedance inputs after reset.
// - External reset repeats the whole sequence.
// - Host waits 25 ms before programming.
// - Decode load, EEPROM bus and speed straps.
// - Pull defaults: SPI, no load, 400 kHz.
// - Port select strap chooses I2C; otherwise address strap B chooses SPI or none.
// - Host programs shared before channel registers.
// - Host writes the five mandatory registers.
// - Calibrate-all and sync-all bits act globally.
// - Analog lock valid only with digital lock.
// - Pin roles configured at 0x0100 to 0x0109.
// - Five interrupt groups: common plus four loops.
// - Unmasked events set sticky monitor bits.
// - Interrupts leave only on assigned pins.
// - Write one clears bit; bit zero clears all.
// - Masks reset to all events disabled.
// - Pin drive mode selectable, default push-pull high.
module sss_dev
  import sss_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supply_good,
  input wire logic [3:0] apll_lock,
  input wire logic [3:0] dpll_lock,
  input wire logic [NIRQ*8-1:0] irq_event,
  output logic core_rst_n,
  output sss_port_t port_mode,
  output logic [6:0] i2c_addr,
  output logic eeprom_load,
  output logic eeprom_bus_en,
  output logic [9:0] eeprom_khz,
  output logic cal_all,
  output logic sync_all,
  sss_link_if.dev lnk
);

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_POR = 4'h2,
    ST_STRAP = 4'h4,
    ST_RUN = 4'h8
  } sss_dstate_t;

  function automatic logic at(input logic [15:0] a, input logic [15:0] base, input int idx);
    return a == (base + 16'(idx));
  endfunction

  function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic act,
                                           input logic lvl);
    logic [1:0] r;
    case (mode)
      DRV_PP_HIGH: r = {lvl, 1'b0};
      DRV_PP_LOW: r = {~lvl, 1'b0};
      DRV_OD_PMOS: r = {1'b1, ~lvl};
      default: r = {1'b0, ~lvl};
    endcase
    if (!act) r = 2'b01;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: supply monitor, external reset and the ten pins.

  logic [NPIN+1:0] meta_q;
  logic [NPIN+1:0] sync_q;
  logic xrst_ok;
  logic sup_ok;
  logic [NPIN-1:0] pins_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 12'h000;
      sync_q <= 12'h000;
    end else begin
      meta_q <= {lnk.ext_reset_n, supply_good, lnk.mfp};
      sync_q <= meta_q;
    end
  end

  assign xrst_ok = sync_q[NPIN+1];
  assign sup_ok = sync_q[NPIN];
  assign pins_s = sync_q[NPIN-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Startup sequence.

  sss_dstate_t st_q;
  sss_dstate_t st_d;
  logic [31:0] cnt_q;
  logic cnt_done;
  logic live_q;

  assign cnt_done = (cnt_q == POR_CYCLES - 32'h1);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: if (sup_ok) st_d = ST_POR;
      ST_POR: if (cnt_done) st_d = ST_STRAP;
      ST_STRAP: if (cnt_done) st_d = ST_RUN;
      ST_RUN: st_d = ST_RUN;
      default: st_d = ST_OFF;
    endcase
    if (!sup_ok) begin
      st_d = ST_OFF;
    end else if (!xrst_ok) begin
      st_d = ST_POR;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) st_q <= ST_OFF;
    else st_q <= st_d;
  end

  // The counter holds at zero while the external pin is low, so the pulse
  // is always a full period measured from the pin's release.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 32'h0;
    else if (st_d != st_q || st_q == ST_OFF || !xrst_ok) cnt_q <= 32'h0;
    else cnt_q <= cnt_q + 32'h1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) live_q <= 1'b0;
    else live_q <= (st_d == ST_STRAP) || (st_d == ST_RUN);
  end

  assign core_rst_n = live_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Straps.

  logic [NPIN-1:0] strap_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) strap_q <= PULL_UP;
    else if (st_q == ST_STRAP && cnt_done) strap_q <= pins_s;
  end

  assign port_mode = sss_port_decode(strap_q[P_PSEL], strap_q[P_ADDR_B]);
  assign i2c_addr = sss_i2c_addr(strap_q);
  assign eeprom_load = strap_q[P_LOAD];
  assign eeprom_bus_en = strap_q[P_EEBUS];
  assign eeprom_khz = strap_q[P_SPEED] ? 10'(EE_FAST_KHZ) : 10'(EE_SLOW_KHZ);

  ////////////////////////////////////////////////////////////////////////////////
  // Global calibrate and sync control.

  logic wr_ok;
  logic [7:0] cs_q;

  assign wr_ok = lnk.wr && live_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= CS_RESET;
      cal_all <= 1'b0;
      sync_all <= 1'b0;
    end else begin
      cal_all <= wr_ok && at(lnk.addr, A_CALSYNC, 0) && lnk.wdata[CS_CAL_ALL];
      sync_all <= wr_ok && at(lnk.addr, A_CALSYNC, 0) && lnk.wdata[CS_SYNC_ALL];
      if (!live_q) cs_q <= CS_RESET;
      else if (wr_ok && at(lnk.addr, A_CALSYNC, 0)) cs_q <= lnk.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt masks, sticky monitors and groups.

  logic clr_all;
  logic [7:0] mask_q [NIRQ];
  logic [7:0] mon_q [NIRQ];
  logic [NIRQ-1:0] mon_any;
  logic [NGRP-1:0] grp_irq;

  assign clr_all = wr_ok && at(lnk.addr, A_CLR0, 0) && lnk.wdata[CLR_ALL_BIT];

  for (genvar k = 0; k < NIRQ; k++) begin : g_irq
    logic [7:0] clr;
    assign clr = (wr_ok && at(lnk.addr, A_CLR1, k)) ? lnk.wdata : {8{clr_all}};

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) mask_q[k] <= MASK_RESET;
      else if (!live_q) mask_q[k] <= MASK_RESET;
      else if (wr_ok && at(lnk.addr, A_MASK0, k)) mask_q[k] <= lnk.wdata;
    end

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) mon_q[k] <= 8'h00;
      else if (!live_q) mon_q[k] <= 8'h00;
      else mon_q[k] <= (mon_q[k] & ~clr) | (irq_event[k*8 +: 8] & mask_q[k]);
    end

    assign mon_any[k] = |mon_q[k];
  end

  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    assign grp_irq[g] = |mon_any[g*REGS_PER_GRP +: REGS_PER_GRP];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Multifunction pin roles and drivers.

  logic [7:0] pin_q [NPIN];
  logic [NPIN-1:0] drv_out;
  logic [NPIN-1:0] drv_oen;

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic [2:0] fn;
    logic act;
    logic lvl;

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) pin_q[i] <= PIN_RESET;
      else if (!live_q) pin_q[i] <= PIN_RESET;
      else if (wr_ok && at(lnk.addr, A_PIN0, i)) pin_q[i] <= lnk.wdata;
    end

    assign fn = pin_q[i][PIN_FN_LSB +: PIN_FN_W];

    // EEPROM pins stay released while the EEPROM master owns them.
    always_comb begin
      act = 1'b1;
      lvl = 1'b0;
      if (fn == FN_IRQ_ALL) begin
        lvl = |grp_irq;
      end else if (fn >= FN_IRQ_G0 && fn < FN_IRQ_GEND) begin
        lvl = grp_irq[fn - FN_IRQ_G0];
      end else begin
        act = 1'b0;
      end
      if (eeprom_bus_en && (i == P_EE_CLK || i == P_EE_DAT)) act = 1'b0;
    end

    assign {drv_out[i], drv_oen[i]} = pin_drive(pin_q[i][PIN_DRV_LSB +: 2], act, lvl);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.pin_out <= 10'h000;
      lnk.pin_oe_n <= 10'h3ff;
    end else if (!live_q) begin
      lnk.pin_out <= 10'h000;
      lnk.pin_oe_n <= 10'h3ff;
    end else begin
      lnk.pin_out <= drv_out;
      lnk.pin_oe_n <= drv_oen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read-back, data valid in the cycle after the read strobe.

  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (at(lnk.addr, A_CALSYNC, 0)) rd_mux = cs_q;
    if (at(lnk.addr, A_ALOCK, 0)) rd_mux = {4'h0, apll_lock};
    if (at(lnk.addr, A_DLOCK, 0)) rd_mux = {4'h0, dpll_lock};
    if (at(lnk.addr, A_STRAP, 0)) begin
      rd_mux = {3'h0, strap_q[P_SPEED], eeprom_bus_en, eeprom_load, port_mode};
    end
    for (int k = 0; k < NIRQ; k++) begin
      if (at(lnk.addr, A_MASK0, k)) rd_mux = mask_q[k];
      if (at(lnk.addr, A_MON0, k)) rd_mux = mon_q[k];
    end
    for (int i = 0; i < NPIN; i++) begin
      if (at(lnk.addr, A_PIN0, i)) rd_mux = pin_q[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) lnk.rdata <= 8'h00;
    else lnk.rdata <= (lnk.rd && live_q) ? rd_mux : 8'h00;
  end

endmodule

// ===== rtl/sss_host.sv
`timescale 1ns/1ns
module sss_host
  import sss_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES = POR_CYC + HOST_MARGIN_CYC,
  parameter logic [7:0] INIT_DATA = 8'h00
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] uaddr,
  input wire logic [7:0] uwdata,
  input wire logic uwr,
  input wire logic urd,
  output logic [7:0] urdata,
  sss_link_if.host lnk
);

  typedef enum logic [6:0] {
    H_RST = 7'h01,
    H_WAIT = 7'h02,
    H_IDLE = 7'h04,
    H_INIT = 7'h08,
    H_CAL = 7'h10,
    H_LK0 = 7'h20,
    H_LK1 = 7'h40
  } sss_hstate_t;

  sss_hstate_t st_q;
  logic [31:0] cnt_q;
  logic [2:0] idx_q;
  logic done_q;
  logic [15:0] daddr_q;
  logic [1:0] tag_q;
  logic [1:0] tag2_q;
  logic [7:0] drdata_q;
  logic [3:0] alock_q;
  logic [3:0] dlock_q;
  logic ctrl_wr;
  logic idle;

  assign ctrl_wr = uwr && (uaddr == HR_CTRL);
  assign idle = (st_q == H_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer. A reset pulse always starts the device from a known point.

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= H_RST;
      cnt_q <= 32'h0;
      idx_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      case (st_q)
        H_RST: if (cnt_q == 32'(EXT_RST_CYC - 1)) begin
          st_q <= H_WAIT;
          cnt_q <= 32'h0;
        end
        H_WAIT: if (cnt_q == WAIT_CYCLES - 32'h1) st_q <= H_IDLE;
        H_IDLE: begin
          cnt_q <= 32'h0;
          idx_q <= 3'h0;
          if (ctrl_wr && uwdata[HC_RESET]) begin
            st_q <= H_RST;
            done_q <= 1'b0;
          end else if (ctrl_wr && uwdata[HC_INIT]) begin
            st_q <= H_INIT;
            done_q <= 1'b0;
          end
        end
        H_INIT: begin
          idx_q <= idx_q + 3'h1;
          if (idx_q == 3'(INIT_N - 1)) st_q <= H_CAL;
        end
        H_CAL: st_q <= H_LK0;
        H_LK0: st_q <= H_LK1;
        H_LK1: begin
          st_q <= H_IDLE;
          done_q <= 1'b1;
        end
        default: st_q <= H_RST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link drive. User device accesses are dropped unless the host is idle.

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.addr <= 16'h0000;
      lnk.wdata <= 8'h00;
      lnk.wr <= 1'b0;
      lnk.rd <= 1'b0;
      lnk.ext_reset_n <= 1'b0;
      tag_q <= 2'h0;
    end else begin
      lnk.wr <= 1'b0;
      lnk.rd <= 1'b0;
      tag_q <= 2'h0;
      lnk.ext_reset_n <= (st_q != H_RST);
      case (st_q)
        H_INIT: begin
          lnk.addr <= INIT_ADDR[idx_q];
          lnk.wdata <= INIT_DATA;
          lnk.wr <= 1'b1;
        end
        H_CAL: begin
          lnk.addr <= A_CALSYNC;
          lnk.wdata <= CS_CAL_ALL_MASK;
          lnk.wr <= 1'b1;
        end
        H_LK0: begin
          lnk.addr <= A_ALOCK;
          lnk.rd <= 1'b1;
          tag_q <= 2'h1;
        end
        H_LK1: begin
          lnk.addr <= A_DLOCK;
          lnk.rd <= 1'b1;
          tag_q <= 2'h2;
        end
        H_IDLE: if (uwr && uaddr == HR_DWDATA) begin
          lnk.addr <= daddr_q;
          lnk.wdata <= uwdata;
          lnk.wr <= 1'b1;
        end else if (uwr && uaddr == HR_DREAD) begin
          lnk.addr <= daddr_q;
          lnk.rd <= 1'b1;
          tag_q <= 2'h3;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read capture, two edges after the strobe leaves the host.

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tag2_q <= 2'h0;
      drdata_q <= 8'h00;
      alock_q <= 4'h0;
      dlock_q <= 4'h0;
    end else begin
      tag2_q <= tag_q;
      case (tag2_q)
        2'h1: alock_q <= lnk.rdata[3:0];
        2'h2: dlock_q <= lnk.rdata[3:0];
        2'h3: drdata_q <= lnk.rdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // User registers.

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      daddr_q <= 16'h0000;
    end else if (uwr && uaddr == HR_DADDR_LO) begin
      daddr_q[7:0] <= uwdata;
    end else if (uwr && uaddr == HR_DADDR_HI) begin
      daddr_q[15:8] <= uwdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      urdata <= 8'h00;
    end else if (!urd) begin
      urdata <= 8'h00;
    end else begin
      case (uaddr)
        HR_STATUS: urdata <= {5'h00, |tag_q | |tag2_q, done_q, idle};
        HR_DADDR_LO: urdata <= daddr_q[7:0];
        HR_DADDR_HI: urdata <= daddr_q[15:8];
        HR_DRDATA: urdata <= drdata_q;
        HR_LOCK: urdata <= {4'h0, alock_q & dlock_q};
        default: urdata <= 8'h00;
      endcase
    end
  end

endmodule

// ===== rtl/sss_link_if.sv
`timescale 1ns/1ns
interface sss_link_if;
  import sss_pkg::*;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic ext_reset_n;
  logic [NPIN-1:0] pin_out;
  logic [NPIN-1:0] pin_oe_n;
  logic [NPIN-1:0] board_out;
  logic [NPIN-1:0] board_oe_n;
  logic [NPIN-1:0] mfp;

  // Device wins, then the board, then the weak pulls.
  assign mfp = (~pin_oe_n & pin_out) | (pin_oe_n & ~board_oe_n & board_out) |
               (pin_oe_n & board_oe_n & PULL_UP);

  modport dev (
    input addr, wdata, wr, rd, ext_reset_n, mfp,
    output rdata, pin_out, pin_oe_n
  );
  modport host (
    output addr, wdata, wr, rd, ext_reset_n,
    input rdata, mfp
  );
endinterface

// ===== rtl/sss_pkg.sv
package sss_pkg;
  // Timing, 100 MHz core clock.
  localparam int CLK_MHZ = 100;
  localparam int POR_MS = 25;
  localparam int POR_CYC = POR_MS * 1000 * CLK_MHZ;
  localparam int HOST_MARGIN_CYC = 8;
  localparam int EXT_RST_CYC = 4;
  localparam int EE_FAST_KHZ = 400;
  localparam int EE_SLOW_KHZ = 100;

  // Sizes.
  localparam int NPIN = 10;
  localparam int NGRP = 5;
  localparam int REGS_PER_GRP = 3;
  localparam int NIRQ = NGRP * REGS_PER_GRP;
  localparam int INIT_N = 5;

  // Device register map.
  localparam logic [15:0] A_PIN0 = 16'h0100;
  localparam logic [15:0] A_MASK0 = 16'h010f;
  localparam logic [15:0] A_CALSYNC = 16'h0a00;
  localparam logic [15:0] A_CLR0 = 16'h0a05;
  localparam logic [15:0] A_CLR1 = 16'h0a06;
  localparam logic [15:0] A_ALOCK = 16'h0d00;
  localparam logic [15:0] A_DLOCK = 16'h0d02;
  localparam logic [15:0] A_STRAP = 16'h0d04;
  localparam logic [15:0] A_MON0 = 16'h0d08;
  localparam logic [15:0] INIT_ADDR [INIT_N] = '{16'h0fff, 16'h1488, 16'h1588, 16'h1688,
                                                 16'h1788};

  // Fields and reset values.
  localparam int CS_CAL_ALL = 1;
  localparam int CS_SYNC_ALL = 3;
  localparam logic [7:0] CS_RESET = 8'h00;
  localparam logic [7:0] CS_CAL_ALL_MASK = 8'h02;
  localparam int CLR_ALL_BIT = 0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] PIN_RESET = 8'h00;
  localparam int PIN_FN_LSB = 0;
  localparam int PIN_FN_W = 3;
  localparam int PIN_DRV_LSB = 4;
  localparam logic [2:0] FN_INPUT = 3'h0;
  localparam logic [2:0] FN_IRQ_ALL = 3'h1;
  localparam logic [2:0] FN_IRQ_G0 = 3'h2;
  localparam logic [2:0] FN_IRQ_GEND = 3'h7;
  localparam logic [1:0] DRV_PP_HIGH = 2'h0;
  localparam logic [1:0] DRV_PP_LOW = 2'h1;
  localparam logic [1:0] DRV_OD_PMOS = 2'h2;
  localparam logic [1:0] DRV_OD_NMOS = 2'h3;

  // Strap pins and their pull defaults.
  localparam int P_ADDR_A = 0;
  localparam int P_EE_CLK = 1;
  localparam int P_EE_DAT = 2;
  localparam int P_LOAD = 3;
  localparam int P_EEBUS = 4;
  localparam int P_PSEL = 5;
  localparam int P_ADDR_B = 6;
  localparam int P_ADDR_C = 7;
  localparam int P_SPEED = 8;
  localparam logic [NPIN-1:0] PULL_UP = 10'h140;
  localparam logic [3:0] I2C_ADDR_HI = 4'hd;

  // Host user registers.
  localparam logic [3:0] HR_CTRL = 4'h0;
  localparam logic [3:0] HR_STATUS = 4'h1;
  localparam logic [3:0] HR_DADDR_LO = 4'h2;
  localparam logic [3:0] HR_DADDR_HI = 4'h3;
  localparam logic [3:0] HR_DWDATA = 4'h4;
  localparam logic [3:0] HR_DREAD = 4'h5;
  localparam logic [3:0] HR_DRDATA = 4'h6;
  localparam logic [3:0] HR_LOCK = 4'h7;
  localparam int HC_INIT = 0;
  localparam int HC_RESET = 1;

  typedef enum logic [1:0] {
    SSS_PORT_NONE = 2'h0,
    SSS_PORT_SPI = 2'h1,
    SSS_PORT_I2C = 2'h2
  } sss_port_t;

  function automatic sss_port_t sss_port_decode(input logic psel, input logic addr_b);
    if (psel) return SSS_PORT_I2C;
    return addr_b ? SSS_PORT_SPI : SSS_PORT_NONE;
  endfunction

  function automatic logic [6:0] sss_i2c_addr(input logic [NPIN-1:0] s);
    return {I2C_ADDR_HI, s[P_ADDR_A], s[P_ADDR_C], s[P_ADDR_B]};
  endfunction
endpackage

// ===== verification/sss_props.sv
`timescale 1ns/1ns
module sss_props
  import sss_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic core_rst_n,
  input wire logic cal_all,
  input wire logic sync_all,
  input wire sss_port_t port_mode,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic ext_reset_n,
  input wire logic [NPIN-1:0] pin_oe_n
);
  // Counters replace long repetitions, which the tools would have to unroll.
  int unsigned low_q;
  int unsigned high_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 0;
      high_q <= 0;
    end else begin
      low_q <= core_rst_n ? 0 : low_q + 1;
      high_q <= !core_rst_n ? 0 : (high_q < 1000 ? high_q + 1 : high_q);
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  a_por_length: assert property ($rose(core_rst_n) |-> low_q >= POR_CYCLES)
    else $error("Core reset released too early.");
  a_ext_reset: assert property ($fell(ext_reset_n) |-> ##[1:6] !core_rst_n)
    else $error("External reset did not reset the core.");
  a_no_early: assert property (!core_rst_n |-> !wr && !rd)
    else $error("Host accessed the device during reset.");
  a_pins_hiz: assert property (!core_rst_n && !$past(core_rst_n) |-> &pin_oe_n)
    else $error("Pin driven during reset.");
  a_init_order: assert property (wr && addr == INIT_ADDR[0] |=>
    wr && addr == INIT_ADDR[1] ##1 wr && addr == INIT_ADDR[2] ##1
    wr && addr == INIT_ADDR[3] ##1 wr && addr == INIT_ADDR[4] ##1
    wr && addr == A_CALSYNC)
    else $error("Mandatory write order broken.");
  a_cal_pulse: assert property (wr && addr == A_CALSYNC && wdata[CS_CAL_ALL] |=>
    cal_all ##1 !cal_all)
    else $error("Calibrate-all pulse wrong.");
  a_sync_pulse: assert property (wr && addr == A_CALSYNC && wdata[CS_SYNC_ALL] |=>
    sync_all ##1 !sync_all)
    else $error("Sync-all pulse wrong.");
  a_cal_cause: assert property ($rose(cal_all) |-> $past(wr) && $past(addr) == A_CALSYNC)
    else $error("Calibrate-all without a write.");
  a_strap_hold: assert property (high_q > POR_CYCLES + 4 |-> $stable(port_mode))
    else $error("Latched strap changed.");
  c_init: cover property (wr && addr == INIT_ADDR[0]);
  c_cal: cover property (cal_all);
  c_core_up: cover property ($rose(core_rst_n));
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import sss_pkg::*;
  localparam int POR_T = 50;
  typedef struct packed {
    logic [9:0] strap;
    sss_port_t port;
    logic [6:0] addr;
    logic load;
    logic eebus;
    logic [9:0] khz;
  } sss_row_t;
  localparam sss_row_t ROWS [6] = '{
    '{10'h020, SSS_PORT_I2C, 7'h68, 1'b0, 1'b0, 10'h064},
    '{10'h1e1, SSS_PORT_I2C, 7'h6f, 1'b0, 1'b0, 10'h190},
    '{10'h068, SSS_PORT_I2C, 7'h69, 1'b1, 1'b0, 10'h064},
    '{10'h091, SSS_PORT_NONE, 7'h6e, 1'b0, 1'b1, 10'h064},
    '{10'h141, SSS_PORT_SPI, 7'h6d, 1'b0, 1'b0, 10'h190},
    '{10'h0a0, SSS_PORT_I2C, 7'h6a, 1'b0, 1'b0, 10'h064}};
  // Pin 9 levels per drive mode, bit m for mode m; the board pulls pin 9 high.
  localparam logic [3:0] IDLE_LVL = 4'he;
  localparam logic [3:0] IDLE_OEN = 4'hc;
  localparam logic [3:0] ACT_LVL = 4'h5;
  logic mclk, rst_n, supply_good, uwr, urd, core_rst_n, eeprom_load, eeprom_bus_en;
  logic cal_all, sync_all;
  logic [3:0] apll_lock, dpll_lock, uaddr;
  logic [7:0] uwdata, urdata, v;
  logic [NIRQ*8-1:0] irq_event;
  logic [6:0] i2c_addr;
  logic [9:0] eeprom_khz;
  sss_port_t port_mode;
  int num_errors, tests_run, i, m;
  sss_link_if lnk ();
  sss_dev #(.POR_CYCLES(POR_T)) sss_dev_inst (.mclk(mclk), .rst_n(rst_n),
    .supply_good(supply_good), .apll_lock(apll_lock), .dpll_lock(dpll_lock),
    .irq_event(irq_event), .core_rst_n(core_rst_n), .port_mode(port_mode),
    .i2c_addr(i2c_addr), .eeprom_load(eeprom_load), .eeprom_bus_en(eeprom_bus_en),
    .eeprom_khz(eeprom_khz), .cal_all(cal_all), .sync_all(sync_all), .lnk(lnk));
  sss_host #(.WAIT_CYCLES(POR_T + 10)) sss_host_inst (.mclk(mclk), .rst_n(rst_n),
    .uaddr(uaddr), .uwdata(uwdata), .uwr(uwr), .urd(urd), .urdata(urdata), .lnk(lnk));
  sss_props #(.POR_CYCLES(POR_T)) sss_props_inst (.mclk(mclk), .rst_n(rst_n),
    .core_rst_n(core_rst_n), .cal_all(cal_all), .sync_all(sync_all),
    .port_mode(port_mode), .addr(lnk.addr), .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd),
    .ext_reset_n(lnk.ext_reset_n), .pin_oe_n(lnk.pin_oe_n));
  always #5 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic uw(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    uaddr <= a;
    uwdata <= d;
    uwr <= 1'b1;
    @(posedge mclk);
    uwr <= 1'b0;
  endtask
  task automatic ur(input logic [3:0] a);
    @(posedge mclk);
    uaddr <= a;
    urd <= 1'b1;
    @(posedge mclk);
    urd <= 1'b0;
    #1 v = urdata;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    v = 8'h00;
    while (v[0] !== 1'b1 && n < 400) begin
      ur(HR_STATUS);
      n++;
    end
    chk("host idle", 16'h0001, {15'h0, v[0]});
  endtask
  task automatic dev_wr(input logic [15:0] a, input logic [7:0] d);
    uw(HR_DADDR_LO, a[7:0]);
    uw(HR_DADDR_HI, a[15:8]);
    uw(HR_DWDATA, d);
    tick(2);
  endtask
  task automatic dev_rd(input logic [15:0] a, input logic [7:0] exp, input string name);
    uw(HR_DADDR_LO, a[7:0]);
    uw(HR_DADDR_HI, a[15:8]);
    uw(HR_DREAD, 8'h00);
    tick(3);
    ur(HR_DRDATA);
    chk(name, {8'h0, exp}, {8'h0, v});
  endtask
  // The straps latch well after the host turns idle, so a fixed wait follows.
  task automatic dev_reset();
    uw(HR_CTRL, 8'h02);
    tick(2);
    wait_idle();
    tick(POR_T + 20);
  endtask
  task automatic pulse(input int b);
    @(posedge mclk);
    irq_event[b] <= 1'b1;
    @(posedge mclk);
    irq_event[b] <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
  initial begin
    mclk = 0;
    rst_n = 0;
    supply_good = 1;
    apll_lock = 0;
    dpll_lock = 0;
    irq_event = '0;
    uaddr = 0;
    uwdata = 0;
    uwr = 0;
    urd = 0;
    lnk.board_out = '0;
    lnk.board_oe_n = '1;
    num_errors = 0;
    tests_run = 0;
    tick(6);
    rst_n = 1;
    chk("core_rst_n", 16'h0, {15'h0, core_rst_n});
    wait_idle();
    tick(POR_T + 20);
    for (i = 0; i < 6; i++) begin
      lnk.board_out <= ROWS[i].strap;
      lnk.board_oe_n <= '0;
      dev_reset();
      chk("port", 16'(ROWS[i].port), 16'(port_mode));
      chk("i2c addr", 16'(ROWS[i].addr), 16'(i2c_addr));
      chk("load", 16'(ROWS[i].load), 16'(eeprom_load));
      chk("eebus", 16'(ROWS[i].eebus), 16'(eeprom_bus_en));
      chk("khz", 16'(ROWS[i].khz), 16'(eeprom_khz));
      lnk.board_out <= ~ROWS[i].strap;
      tick(4);
      chk("held addr", 16'(ROWS[i].addr), 16'(i2c_addr));
    end
    lnk.board_oe_n <= '1;
    dev_reset();
    chk("default port", 16'(SSS_PORT_SPI), 16'(port_mode));
    chk("default addr", 16'h0069, 16'(i2c_addr));
    dev_rd(A_STRAP, 8'h11, "strap readback");
    apll_lock <= 4'hf;
    dpll_lock <= 4'h5;
    uw(HR_CTRL, 8'h01);
    tick(2);
    wait_idle();
    ur(HR_LOCK);
    chk("valid lock", 16'h0005, {8'h0, v});
    dev_wr(A_CALSYNC, 8'h08);
    dev_rd(A_CALSYNC, 8'h08, "cal sync reg");
    dev_rd(A_ALOCK, 8'h0f, "analog lock");
    dev_rd(A_MASK0, MASK_RESET, "mask reset");
    pulse(0);
    dev_rd(A_MON0, 8'h00, "masked event");
    dev_wr(A_MASK0, 8'h01);
    lnk.board_out <= 10'h200;
    lnk.board_oe_n <= 10'h1ff;
    for (m = 0; m < 4; m++) begin
      dev_wr(A_PIN0 + 16'h0009, {2'h0, m[1:0], 1'b0, FN_IRQ_ALL});
      chk("idle level", 16'(IDLE_LVL[m]), 16'(lnk.mfp[9]));
      chk("idle oe_n", 16'(IDLE_OEN[m]), 16'(lnk.pin_oe_n[9]));
      pulse(0);
      tick(4);
      chk("irq level", 16'(ACT_LVL[m]), 16'(lnk.mfp[9]));
      dev_rd(A_MON0, 8'h01, "monitor set");
      chk("irq held", 16'(ACT_LVL[m]), 16'(lnk.mfp[9]));
      dev_wr(A_CLR0, 8'h01);
    end
    dev_rd(A_MON0, 8'h00, "clear all");
    dev_wr(A_MASK0 + 16'h0004, 8'h04);
    dev_wr(A_PIN0 + 16'h0009, {5'h00, FN_IRQ_G0 + 3'h1});
    pulse(0);
    tick(4);
    chk("group pin quiet", 16'h0, 16'(lnk.mfp[9]));
    pulse(34);
    tick(4);
    chk("group pin", 16'h1, 16'(lnk.mfp[9]));
    dev_wr(A_CLR1 + 16'h0004, 8'h04);
    chk("group pin clear", 16'h0, 16'(lnk.mfp[9]));
    dev_rd(A_MON0 + 16'h0004, 8'h00, "single clear");
    dev_rd(A_MON0, 8'h01, "other kept");
    dev_rd(16'h2000, 8'h00, "unmapped");
    ur(4'hf);
    chk("user unmapped", 16'h0, {8'h0, v});
    supply_good <= 1'b0;
    tick(6);
    chk("supply drop", 16'h0, {15'h0, core_rst_n});
    supply_good <= 1'b1;
    tick(POR_T - 10);
    chk("por early", 16'h0, {15'h0, core_rst_n});
    tick(20);
    chk("por done", 16'h1, {15'h0, core_rst_n});
    rst_n <= 1'b0;
    tick(3);
    chk("pins hiz", 16'h03ff, 16'(lnk.pin_oe_n));
    rst_n <= 1'b1;
    wait_idle();
    print_verdict();
  end
endmodule
